// ### tfm_monitor.sv
// Status, interrupt and driver control logic of the fault monitor
`timescale 1ns/10ps
`include "tfm_regs.svh"

module tfm_monitor
	import tfm_pkg::*;
#(
	parameter int WAKE_CYC  = `TFM_WAKE_US * `TFM_CLK_MHZ,
	parameter int PULSE_CYC = `TFM_PULSE_US * `TFM_CLK_MHZ,
	parameter int BLPIN_CYC = `TFM_BLPIN_US * `TFM_CLK_MHZ,
	parameter int BL0_CYC   = `TFM_BL0_US * `TFM_CLK_MHZ,
	parameter int BL1_CYC   = `TFM_BL1_US * `TFM_CLK_MHZ,
	parameter int BL2_CYC   = `TFM_BL2_US * `TFM_CLK_MHZ,
	parameter int BL3_CYC   = `TFM_BL3_US * `TFM_CLK_MHZ
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pins and analog comparators
	input  wire logic        port_select,
	input  wire logic        tx_data,
	input  wire logic        line_drive_enable,
	input  wire logic        aux_level_in,
	input  wire logic        line_short,
	input  wire logic        line_oc,
	input  wire logic        aux_oc,
	input  wire logic        uv_main,
	input  wire logic        uv_5v,
	input  wire logic        uv_logic,
	input  wire logic        uv_3v3,
	input  wire logic        supply_low,
	input  wire logic        supply_lockout,
	input  wire logic        temp_warn_hi,
	input  wire logic        temp_warn_lo,
	input  wire logic        temp_shutdown,
	input  wire logic        int_5v_used,
	// Driver, regulator, alert and wake outputs
	output logic             line_drive_on,
	output logic             line_level_out,
	output logic             aux_drive_on,
	output logic             aux_level_out,
	output logic             alert_n,
	output logic             wake_pulse_n,
	output logic             ldo5v_en,
	output logic             ldo3v3_en
);

	localparam int CW = 20;
	localparam int CMAX = 1 << CW;

	// ********************
	// Parameter checks
	// ********************
	if (WAKE_CYC < 2 || PULSE_CYC < 1 || BLPIN_CYC < 1 || BL0_CYC < 1 ||
	    BL1_CYC < 1 || BL2_CYC < 1 || BL3_CYC < 1 || WAKE_CYC >= CMAX ||
	    PULSE_CYC >= CMAX || BLPIN_CYC >= CMAX || BL0_CYC >= CMAX ||
	    BL1_CYC >= CMAX || BL2_CYC >= CMAX || BL3_CYC >= CMAX) begin : g_chk
		$error("tfm_monitor: timing parameter out of range");
	end

	// ********************
	// Input synchronisers
	// ********************
	tfm_cond_t sync1_r;
	tfm_cond_t c;
	tfm_cond_t prev_r;
	tfm_cond_t pins;
	assign pins = '{port_select, tx_data, line_drive_enable, aux_level_in,
		line_short, line_oc, aux_oc, uv_main, uv_5v, uv_logic, uv_3v3,
		supply_low, supply_lockout, temp_warn_hi, temp_warn_lo,
		temp_shutdown, int_5v_used};
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= '0;
			c       <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= pins;
			c       <= sync1_r;
			prev_r  <= c;
		end
	end

	// ********************
	// Register bus decode
	// ********************
	logic [7:0] lcfg_r;
	logic [7:0] clim_r;
	logic [7:0] mode_r;
	tfm_irq_t   irq_r;
	tfm_irq_t   irq_nxt;
	logic       ack_r;
	logic [31:0] dat_r;
	logic       ot_r;
	logic       soft_rst;
	wire req     = wb_cyc_i & wb_stb_i;
	wire done    = req & ack_r;
	wire wr_lane = done & wb_we_i & wb_sel_i[0];
	wire hit_lcfg = wb_adr_i == `TFM_ADR_LCFG;
	wire hit_clim = wb_adr_i == `TFM_ADR_CLIM;
	wire hit_mode = wb_adr_i == `TFM_ADR_MODE;
	wire hit_stat = wb_adr_i == `TFM_ADR_STAT;
	wire hit_irq  = wb_adr_i == `TFM_ADR_IRQ;
	// Irq read clears at the ack edge
	wire rd_clr  = done & ~wb_we_i & hit_irq;
	wire serial  = c.serial;
	wire track   = serial & lcfg_r[`TFM_LCFG_TRACK];
	wire [5:0] stat;
	logic [31:0] rd_mux;
	assign stat = serial ? {c.shutdown, ot_r, c.lockout, c.low,
		c.aux_oc, c.line_oc} : 6'h00;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_lcfg) begin
			rd_mux[7:0] = lcfg_r;
		end else if (hit_clim) begin
			rd_mux[7:0] = clim_r;
		end else if (hit_mode) begin
			rd_mux[7:0] = mode_r;
		end else if (hit_stat) begin
			rd_mux[5:0] = stat;
		end else if (hit_irq) begin
			rd_mux[6:0] = irq_r;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			dat_r <= rd_mux;
		end
	end

	// ********************
	// Control registers
	// ********************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lcfg_r <= `TFM_LCFG_RST;
			clim_r <= `TFM_CLIM_RST;
			mode_r <= `TFM_MODE_RST;
		end else if (soft_rst) begin
			lcfg_r <= `TFM_LCFG_RST;
			clim_r <= `TFM_CLIM_RST;
			mode_r <= `TFM_MODE_RST;
		end else if (wr_lane) begin
			if (hit_lcfg)
				lcfg_r <= wb_dat_i[7:0];
			if (hit_clim)
				clim_r <= wb_dat_i[7:0];
			if (hit_mode)
				mode_r <= wb_dat_i[7:0];
		end
	end

	// ********************
	// Thermal restart
	// ********************
	// regulator back on
	assign soft_rst = prev_r.shutdown & ~c.shutdown & c.int5v;

	// ********************
	// Overtemp hysteresis
	// ********************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			ot_r <= 1'b0;
		else if (~serial | c.t_lo | soft_rst)
			ot_r <= 1'b0;
		else if (c.t_hi)
			ot_r <= 1'b1;
	end

	// ********************
	// Wake detection
	// ********************
	logic [CW-1:0] short_cnt_r;
	logic [CW-1:0] pulse_cnt_r;
	logic [CW-1:0] pulse_nxt;
	logic [CW-1:0] blank_cyc;
	logic          wake_n_r;

	always_comb begin
		blank_cyc = CW'(BLPIN_CYC);
		if (serial) begin
			case ({clim_r[`TFM_CLIM_BHI], clim_r[`TFM_CLIM_BLO]})
			2'b00:   blank_cyc = CW'(BL0_CYC);
			2'b01:   blank_cyc = CW'(BL1_CYC);
			2'b10:   blank_cyc = CW'(BL2_CYC);
			default: blank_cyc = CW'(BL3_CYC);
			endcase
		end
	end
	// A short shorter than the blanking time is never a wake
	wire [CW-1:0] wake_thr = (blank_cyc > CW'(WAKE_CYC)) ?
		blank_cyc : CW'(WAKE_CYC);
	wire wake_en  = ~serial | mode_r[`TFM_MODE_WAKE];
	wire wake_hit = wake_en & c.shorted &
		(short_cnt_r == wake_thr - CW'(1));
	assign pulse_nxt = wake_hit ? CW'(PULSE_CYC) :
		(pulse_cnt_r != '0) ? pulse_cnt_r - CW'(1) : '0;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			short_cnt_r <= '0;
			pulse_cnt_r <= '0;
			wake_n_r    <= 1'b1;
		end else begin
			if (~c.shorted | ~wake_en | soft_rst)
				short_cnt_r <= '0;
			else if (short_cnt_r != wake_thr)
				short_cnt_r <= short_cnt_r + CW'(1);
			pulse_cnt_r <= pulse_nxt;
			wake_n_r    <= (pulse_nxt == '0);
		end
	end

	assign wake_pulse_n = wake_n_r;

	// ********************
	// Interrupt flags
	// ********************
	tfm_irq_t evt;
	// Events are one-cycle pulses (input rising edges, wake hit, overtemp latch set) so a read clears a standing fault
	// event sources
	assign evt.line_fault = serial & c.line_oc & ~prev_r.line_oc;
	assign evt.aux_fault  = serial & c.aux_oc & ~prev_r.aux_oc;
	assign evt.low_warn   = serial & mode_r[`TFM_MODE_LWEN] &
		c.low & ~prev_r.low;
	assign evt.undervolt  = serial & c.lockout & ~prev_r.lockout;
	assign evt.wake       = serial & wake_hit;
	assign evt.overtemp   = serial & c.t_hi & ~ot_r & ~c.t_lo;
	assign evt.thermal    = serial & c.shutdown & ~prev_r.shutdown;
	// clear on read or thermal restart; set wins over read, restart wins over set
	assign irq_nxt = soft_rst ? '0 :
		((rd_clr ? '0 : irq_r) | evt);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			irq_r <= '0;
		else
			irq_r <= irq_nxt;
	end

	// ********************
	// Driver control
	// ********************
	// supply and thermal shutdown hold off
	wire hold = c.uv_main | c.uv_5v | c.uv_logic | c.uv_3v3 | c.shutdown;
	wire line_lvl = ~c.tx | (serial & lcfg_r[`TFM_LCFG_LEVEL]);
	logic line_on_r;
	logic line_lvl_r;
	logic aux_on_r;
	logic aux_lvl_r;
	logic alert_n_r;
	logic ldo5_r;
	logic ldo33_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			line_on_r  <= 1'b0;
			line_lvl_r <= 1'b0;
			aux_on_r   <= 1'b0;
			aux_lvl_r  <= 1'b0;
		end else begin
			line_on_r  <= c.drv_en & ~hold;
			line_lvl_r <= line_lvl;
			if (track) begin
				aux_on_r  <= c.drv_en & ~hold;
				aux_lvl_r <= line_lvl;
			end else begin
				aux_on_r  <= ~hold;
				aux_lvl_r <= ~c.aux_in;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			alert_n_r <= 1'b1;
			ldo5_r    <= 1'b0;
			ldo33_r   <= 1'b0;
		end else begin
			// any irq bit, live fault in pin mode
			alert_n_r <= serial ? ~(|irq_nxt) : ~(c.line_oc | c.aux_oc);
			ldo5_r    <= ~c.shutdown;
			ldo33_r   <= ~c.shutdown &
				~(serial & mode_r[`TFM_MODE_LDO]);
		end
	end
	assign line_drive_on  = line_on_r;
	assign line_level_out = line_lvl_r;
	assign aux_drive_on   = aux_on_r;
	assign aux_level_out  = aux_lvl_r;
	assign alert_n        = alert_n_r;
	assign ldo5v_en       = ldo5_r;
	assign ldo3v3_en      = ldo33_r;

	// ********************
	// Assertions
	// ********************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_track_follow: assert property (
		$past(track) |-> aux_drive_on == line_drive_on &&
			aux_level_out == line_level_out)
		else $error("aux does not track line");
	// First edge after reset still shows the reset level
	a_pin_indep: assert property (
		$past(rstn) && $past(~track) |->
			aux_level_out == ~$past(c.aux_in))
		else $error("aux level not independent");
	a_hold_off: assert property (
		$past(hold) |-> ~line_drive_on && ~aux_drive_on)
		else $error("driver on during undervoltage");
	a_pin_alert: assert property (
		$past(~serial) |-> alert_n == ~$past(c.line_oc | c.aux_oc))
		else $error("pin alert wrong");
	a_fault_set: assert property (
		evt.line_fault && ~soft_rst |=> irq_r.line_fault && ~alert_n)
		else $error("line fault irq not set");
	a_irq_sticky: assert property (
		irq_r.aux_fault && ~rd_clr && ~soft_rst |=> irq_r.aux_fault)
		else $error("irq lost without read");
	a_read_clear: assert property (
		rd_clr && evt == '0 && ~soft_rst |=> irq_r == '0)
		else $error("irq not cleared by read");
	a_alert_any: assert property (
		$past(serial) |-> alert_n == ~(|irq_r))
		else $error("alert does not match irq bits");
	a_wake_low: assert property (
		wake_hit |=> ~wake_pulse_n [*8])
		else $error("wake pulse too short");
	a_ldo_off: assert property (
		$past(serial & mode_r[`TFM_MODE_LDO]) |-> ~ldo3v3_en)
		else $error("3.3 V regulator not off");
	a_lowwarn_gate: assert property (
		~mode_r[`TFM_MODE_LWEN] && ~irq_r.low_warn && ~soft_rst
		|=> ~irq_r.low_warn)
		else $error("low warning irq while disabled");

	c_wake: cover property (wake_hit ##1 ~wake_pulse_n);
	c_track: cover property (track && line_drive_on);
	c_clear: cover property (rd_clr && irq_r != '0);
	c_restart: cover property (soft_rst);

endmodule // tfm_monitor

// ### tfm_regs.svh
// Register map, field positions, reset values and timing figures
`ifndef TFM_REGS_SVH
`define TFM_REGS_SVH

// ********************
// Register offsets
// ********************
`define TFM_ADR_LCFG   8'h00
`define TFM_ADR_CLIM   8'h04
`define TFM_ADR_MODE   8'h08
`define TFM_ADR_STAT   8'h0c
`define TFM_ADR_IRQ    8'h10

// ********************
// Field positions
// ********************
`define TFM_LCFG_TRACK 0
`define TFM_LCFG_LEVEL 1
`define TFM_CLIM_LO    0
`define TFM_CLIM_HI    1
`define TFM_CLIM_BLO   2
`define TFM_CLIM_BHI   3
`define TFM_MODE_LWEN  0
`define TFM_MODE_WAKE  1
`define TFM_MODE_LDO   2

// ********************
// Reset values
// ********************
`define TFM_LCFG_RST   8'h00
`define TFM_CLIM_RST   8'h00
`define TFM_MODE_RST   8'h02

// ********************
// Timing
// ********************
`define TFM_CLK_MHZ    200
`define TFM_WAKE_US    80
`define TFM_PULSE_US   200
`define TFM_BLPIN_US   128
`define TFM_BL0_US     16
`define TFM_BL1_US     64
`define TFM_BL2_US     128
`define TFM_BL3_US     512

`endif

// ### tfm_pkg.sv
// Types shared by the fault monitor
package tfm_pkg;

	// Sticky interrupt bits, read order msb first
	typedef struct packed {
		logic thermal;
		logic overtemp;
		logic wake;
		logic undervolt;
		logic low_warn;
		logic aux_fault;
		logic line_fault;
	} tfm_irq_t;

	// Synchronised pin conditions
	typedef struct packed {
		logic serial;
		logic tx;
		logic drv_en;
		logic aux_in;
		logic shorted;
		logic line_oc;
		logic aux_oc;
		logic uv_main;
		logic uv_5v;
		logic uv_logic;
		logic uv_3v3;
		logic low;
		logic lockout;
		logic t_hi;
		logic t_lo;
		logic shutdown;
		logic int5v;
	} tfm_cond_t;

endpackage

// ### tfm_host_model.sv
// Host controller model: classic Wishbone master and port select pin
`timescale 1ns/10ps

module tfm_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Wishbone master
	output logic             wb_cyc,
	output logic             wb_stb,
	output logic             wb_we,
	output logic      [7:0]  wb_adr,
	output logic      [3:0]  wb_sel,
	output logic      [31:0] wb_dat_w,
	input  wire logic [31:0] wb_dat_r,
	input  wire logic        wb_ack,
	// Mode pin
	output logic             port_select
);
	logic timed_out;

	initial begin
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_dat_w = 32'h0;
		port_select = 1'b1;
		timed_out = 1'b0;
	end

	task automatic set_mode(input logic serial);
		@(posedge sys_clk);
		port_select <= serial;
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		int i;
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat_w <= d;
		timed_out = 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			if (wb_ack === 1'b1) begin
				timed_out = 1'b0;
				break;
			end
		end
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		// Released address and data lines never keep the stale value
		wb_adr <= ~a;
		wb_dat_w <= ~d;
	endtask
endmodule // tfm_host_model

// ### tfm_monitor_tb.sv
// Self-checking testbench of the fault monitor
`timescale 1ns/10ps
`include "tfm_regs.svh"

module tfm_monitor_tb;
	// Short counts keep the run brief
	localparam int WAKE_C  = 20;
	localparam int PULSE_C = 10;
	localparam int BLPIN_C = 30;
	localparam int BL3_C   = 40;

	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc, stb, we, ack, port_select;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dw, dr, rd_q;
	logic        tx_data = 1'b1;
	logic        line_drive_enable = 1'b1;
	logic        aux_level_in = 1'b1;
	logic        line_short = 1'b0;
	logic [5:0]  cond = 6'h00;
	logic [3:0]  uv = 4'h0;
	logic        temp_warn_lo = 1'b1;
	logic        int_5v_used = 1'b0;
	logic        ld_on, ld_lvl, ax_on, ax_lvl, alert_n, wake_n, l5, l33;
	logic [7:0]  st_tab [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
	logic [7:0]  iq_tab [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};
	int          n_errors = 0;
	int          n_tests = 0;
	int          k;

	always #2.5 sys_clk = ~sys_clk;

	tfm_host_model tfm_host_model_inst (.sys_clk(sys_clk), .wb_cyc(cyc),
		.wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel),
		.wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
		.port_select(port_select));

	tfm_monitor #(.WAKE_CYC(WAKE_C), .PULSE_CYC(PULSE_C),
		.BLPIN_CYC(BLPIN_C), .BL0_CYC(5), .BL1_CYC(10), .BL2_CYC(25),
		.BL3_CYC(BL3_C)) tfm_monitor_inst (.sys_clk(sys_clk), .rstn(rstn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.port_select(port_select), .tx_data(tx_data),
		.line_drive_enable(line_drive_enable), .aux_level_in(aux_level_in),
		.line_short(line_short), .line_oc(cond[0]), .aux_oc(cond[1]),
		.uv_main(uv[0]), .uv_5v(uv[1]), .uv_logic(uv[2]), .uv_3v3(uv[3]),
		.supply_low(cond[2]), .supply_lockout(cond[3]),
		.temp_warn_hi(cond[4]), .temp_warn_lo(temp_warn_lo),
		.temp_shutdown(cond[5]), .int_5v_used(int_5v_used),
		.line_drive_on(ld_on), .line_level_out(ld_lvl),
		.aux_drive_on(ax_on), .aux_level_out(ax_lvl), .alert_n(alert_n),
		.wake_pulse_n(wake_n), .ldo5v_en(l5), .ldo3v3_en(l33));

	// ********************
	// Shared tasks
	// ********************
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Inputs settle; sample one step after the edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		tfm_host_model_inst.xfer(w, a, {24'h0, d}, s, rd_q);
		if (tfm_host_model_inst.timed_out === 1'b1) begin
			n_errors++;
			$display("[ERR] bus ack expected 1 seen 0");
			print_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hf);
		chk(nm, {24'h0, e}, rd_q);
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_regs;
		rd("lcfg rst", `TFM_ADR_LCFG, `TFM_LCFG_RST);
		rd("clim rst", `TFM_ADR_CLIM, `TFM_CLIM_RST);
		rd("mode rst", `TFM_ADR_MODE, `TFM_MODE_RST);
		rd("unmapped", 8'h20, 8'h00);
		wr(`TFM_ADR_CLIM, 8'h0f);
		rd("clim rw", `TFM_ADR_CLIM, 8'h0f);
		bus(1'b1, `TFM_ADR_LCFG, 8'h03, 4'he);
		rd("lane off", `TFM_ADR_LCFG, 8'h00);
	endtask

	task automatic t_track;
		wr(`TFM_ADR_LCFG, 8'h01);
		@(posedge sys_clk);
		tx_data <= 1'b0;
		step(4);
		chk("trk line", 1, ld_lvl);
		chk("trk aux", 1, ax_lvl);
		@(posedge sys_clk);
		tx_data <= 1'b1;
		step(4);
		chk("trk aux lo", 0, ax_lvl);
		@(posedge sys_clk);
		line_drive_enable <= 1'b0;
		step(4);
		chk("trk en line", 0, ld_on);
		chk("trk en aux", 0, ax_on);
		@(posedge sys_clk);
		line_drive_enable <= 1'b1;
		wr(`TFM_ADR_LCFG, 8'h03);
		step(4);
		chk("lvl aux", 1, ax_lvl);
		wr(`TFM_ADR_LCFG, 8'h00);
		@(posedge sys_clk);
		aux_level_in <= 1'b0;
		line_drive_enable <= 1'b0;
		step(4);
		chk("ind line", 0, ld_lvl);
		chk("ind aux", 1, ax_lvl);
		chk("ind aux on", 1, ax_on);
		chk("ind line off", 0, ld_on);
		@(posedge sys_clk);
		line_drive_enable <= 1'b1;
	endtask

	task automatic t_uv;
		wr(`TFM_ADR_LCFG, 8'h01);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			uv[i] <= 1'b1;
			step(4);
			chk("uv line", 0, ld_on);
			chk("uv aux", 0, ax_on);
			@(posedge sys_clk);
			uv[i] <= 1'b0;
			step(4);
			chk("uv back", 1, ld_on);
		end
		wr(`TFM_ADR_MODE, 8'h06);
		step(3);
		chk("ldo off", 0, l33);
		wr(`TFM_ADR_MODE, 8'h03);
		step(3);
		chk("ldo on", 1, l33);
	endtask

	task automatic t_event(input int c, input logic [7:0] st, input logic [7:0] iq);
		@(posedge sys_clk);
		cond[c] <= 1'b1;
		temp_warn_lo <= (c != 4);
		step(4);
		rd("status", `TFM_ADR_STAT, st);
		chk("alert on", iq == 0, alert_n);
		if (c == 4) begin
			@(posedge sys_clk);
			cond[c] <= 1'b0;
			step(4);
			rd("warn hold", `TFM_ADR_STAT, st);
		end
		@(posedge sys_clk);
		cond[c] <= 1'b0;
		temp_warn_lo <= 1'b1;
		step(4);
		rd("status live", `TFM_ADR_STAT, 8'h00);
		chk("alert held", iq == 0, alert_n);
		rd("irq", `TFM_ADR_IRQ, iq);
		step(2);
		chk("alert off", 1, alert_n);
		rd("irq clr", `TFM_ADR_IRQ, 8'h00);
	endtask

	task automatic t_shut;
		wr(`TFM_ADR_MODE, 8'h03);
		@(posedge sys_clk);
		int_5v_used <= 1'b1;
		cond[5] <= 1'b1;
		step(4);
		chk("shut ldo5", 0, l5);
		chk("shut ldo3", 0, l33);
		chk("shut drv", 0, ld_on);
		rd("shut bus", `TFM_ADR_LCFG, 8'h01);
		@(posedge sys_clk);
		cond[5] <= 1'b0;
		step(4);
		chk("ldo5 back", 1, l5);
		rd("lcfg def", `TFM_ADR_LCFG, `TFM_LCFG_RST);
		rd("mode def", `TFM_ADR_MODE, `TFM_MODE_RST);
		rd("irq def", `TFM_ADR_IRQ, 8'h00);
	endtask

	task automatic t_wake(input logic [3:0] cl, input int thr, input logic [7:0] iq);
		int i;
		int j;
		wr(`TFM_ADR_CLIM, {4'h0, cl});
		@(posedge sys_clk);
		line_short <= 1'b1;
		for (i = 0; i < 50; i++) begin
			step(1);
			if (wake_n === 1'b0) break;
		end
		for (j = 0; j < 50; j++) begin
			if (wake_n !== 1'b0) break;
			step(1);
		end
		@(posedge sys_clk);
		line_short <= 1'b0;
		n_tests++;
		if (thr == 0 ? i != 50 : (i < thr || i > thr + 3)) begin
			n_errors++;
			$display("[ERR] wake delay expected %0d seen %0d", thr, i);
		end
		chk("wake len", (thr == 0) ? 0 : PULSE_C, j);
		rd("wake irq", `TFM_ADR_IRQ, iq);
	endtask

	task automatic t_pin;
		tfm_host_model_inst.set_mode(1'b0);
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			cond[i] <= 1'b1;
			step(4);
			chk("pin alert", 0, alert_n);
			@(posedge sys_clk);
			cond[i] <= 1'b0;
			step(4);
			chk("pin release", 1, alert_n);
		end
		@(posedge sys_clk);
		cond[4] <= 1'b1;
		temp_warn_lo <= 1'b0;
		step(4);
		rd("pin temp", `TFM_ADR_STAT, 8'h00);
		rd("pin irq", `TFM_ADR_IRQ, 8'h00);
		@(posedge sys_clk);
		cond[4] <= 1'b0;
		temp_warn_lo <= 1'b1;
		chk("pin aux", 1, ax_on);
		t_wake(4'h0, BLPIN_C, 8'h00);
	endtask

	initial begin
		step(1);
		chk("rst alert", 1, alert_n);
		chk("rst wake", 1, wake_n);
		@(posedge sys_clk);
		rstn <= 1'b1;
		step(2);
		t_regs();
		t_track();
		t_uv();
		for (k = 0; k < 6; k++) begin
			t_event(k, st_tab[k], iq_tab[k]);
		end
		wr(`TFM_ADR_MODE, 8'h02);
		t_event(2, 8'h04, 8'h00);
		wr(`TFM_ADR_LCFG, 8'h01);
		t_shut();
		t_wake(4'h0, WAKE_C, 8'h10);
		t_wake(4'hc, BL3_C, 8'h10);
		t_wake(4'h8, 25, 8'h10);
		wr(`TFM_ADR_MODE, 8'h00);
		t_wake(4'h0, 0, 8'h00);
		t_pin();
		print_verdict();
	end
endmodule // tfm_monitor_tb
